// [pin_event_if.sv]
// synchronised pin level with its edge and activity indications
interface pin_event_if;
   logic level;   // pin level after two flip-flops
   logic rise;    // one-cycle pulse on a rising edge
   logic fall;    // one-cycle pulse on a falling edge
   logic active;  // an edge was seen within the idle window
   modport src (output level, output rise, output fall, output active);
   modport dst (input level, input rise, input fall, input active);
endinterface : pin_event_if

// [pin_watch.sv]
// pin synchroniser with edge detection and idle timeout
module pin_watch #(
   parameter logic [7:0] IDLE_CYC = 8'h19
) (
   // clock and reset
   input wire logic  clk,
   input wire logic  sys_rst,
   // pin from outside the clock domain
   input wire logic  pin,
   // events
   pin_event_if.src  ev
);
   logic       meta;
   logic       sync;
   logic       prev;
   logic [7:0] idle_cnt;
   logic [1:0] settle;
   // edges count only once all three stages hold the pin's own level,
   // so a pin that idles high makes no false edge after reset
   wire        toggled = (sync ^ prev) & (settle == 2'h3);

   // two-flop synchroniser and one more stage for edges
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
      end
   end

   // settle count after reset, saturates at three
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         settle <= 2'h0;
      end else if (settle != 2'h3) begin
         settle <= settle + 2'h1;
      end
   end

   // idle timer restarts on every edge and saturates
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         idle_cnt <= IDLE_CYC;
      end else if (toggled) begin
         idle_cnt <= 8'h00;
      end else if (idle_cnt != IDLE_CYC) begin
         idle_cnt <= idle_cnt + 8'h01;
      end
   end

   // event outputs
   assign ev.level  = sync;
   assign ev.rise   = toggled & sync;
   assign ev.fall   = toggled & ~sync;
   assign ev.active = (idle_cnt != IDLE_CYC);
endmodule : pin_watch

// [serdes_ctrl_checker.sv]
// port assertions for the serdes enable and failsafe control
module serdes_ctrl_checker #(
   parameter logic [17:0] TX_LOCK_CYCLES = 18'h14,
   parameter logic [17:0] RX_LOCK_CYCLES = 18'h14
) (
   // clock, reset and enables
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        tx_enable,
   input wire logic        rx_enable,
   // observed outputs
   input wire logic        ser_out_oe,
   input wire logic        ser_clk_out_oe,
   input wire logic        ser_clk_out,
   input wire logic [13:0] par_data_out,
   input wire logic        par_clk_out,
   input wire logic        tx_locked,
   input wire logic        rx_locked
);
   logic [17:0] tx_on;
   logic [17:0] rx_on;
   // cycles since each enable went high, saturating
   always_ff @(posedge clk) begin
      tx_on <= (sys_rst || !tx_enable) ? 18'h0 : tx_on + 18'(tx_on != 18'h3ffff);
      rx_on <= (sys_rst || !rx_enable) ? 18'h0 : rx_on + 18'(rx_on != 18'h3ffff);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_TX_OFF_HIZ: assert property (!tx_enable [*6] |-> !ser_out_oe && !ser_clk_out_oe)
      else $error("serial outputs driven while transmit disabled");
   AST_TX_OFF_RESET: assert property (!ser_out_oe |-> !tx_locked)
      else $error("transmit locked while outputs released");
   AST_TX_ON_DRIVE: assert property (tx_enable [*6] |-> ser_out_oe)
      else $error("serial outputs not driven after enable");
   AST_RX_OFF_LOW: assert property (!rx_enable [*6] |-> par_data_out == 14'h0 && !par_clk_out && !rx_locked)
      else $error("receive outputs not low while disabled");
   AST_TX_LOCK_TIME: assert property ($rose(tx_locked) |-> tx_on >= TX_LOCK_CYCLES)
      else $error("transmit locked too early");
   AST_RX_LOCK_TIME: assert property ($rose(rx_locked) |-> rx_on >= RX_LOCK_CYCLES)
      else $error("receive locked too early");
   AST_SER_CLK_GATED: assert property (ser_clk_out |-> tx_locked || $past(tx_locked))
      else $error("forwarded clock while unlocked");
   AST_RX_CLK_GATED: assert property (par_clk_out |-> rx_locked || $past(rx_locked))
      else $error("recovered clock while unlocked");
   AST_RX_HOLD: assert property (rx_enable [*6] ##0 !rx_locked ##1 (rx_enable && !rx_locked) |-> $stable(par_data_out))
      else $error("received word changed without link clock");
   // main scenarios
   cover property ($rose(tx_locked));
   cover property ($rose(rx_locked));
   cover property (rx_locked && par_data_out == 14'h3fff);
   cover property (rx_locked && par_data_out != 14'h3fff && par_data_out != 14'h0);
endmodule : serdes_ctrl_checker

bind serdes_enable_failsafe_ctrl serdes_ctrl_checker #(
   .TX_LOCK_CYCLES(TX_LOCK_CYCLES),
   .RX_LOCK_CYCLES(RX_LOCK_CYCLES)
) u_serdes_ctrl_checker (
   .clk, .sys_rst, .tx_enable, .rx_enable, .ser_out_oe, .ser_clk_out_oe,
   .ser_clk_out, .par_data_out, .par_clk_out, .tx_locked, .rx_locked
);

// [serdes_enable_failsafe_ctrl.sv]
// enable, lock and failsafe control of both serializer and deserializer halves
module serdes_enable_failsafe_ctrl #(
   parameter logic [17:0] TX_LOCK_CYCLES = 18'(serdes_pkg::LOCK_CYC),
   parameter logic [17:0] RX_LOCK_CYCLES = 18'(serdes_pkg::LOCK_CYC)
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // enable and edge select pins
   input  wire logic         tx_enable,
   input  wire logic         rx_enable,
   input  wire logic         edge_select,
   // parallel transmit side
   input  wire logic         par_clk_in,
   input  wire logic [13:0]  par_data_in,
   // serial transmit side
   output logic      [1:0]   ser_out,
   output logic              ser_out_oe,
   output logic              ser_clk_out,
   output logic              ser_clk_out_oe,
   // serial receive side
   input  wire logic [1:0]   ser_in,
   input  wire logic         ser_clk_in,
   // parallel receive side
   output logic      [13:0]  par_data_out,
   output logic              par_clk_out,
   // lock status
   output logic              tx_locked,
   output logic              rx_locked
);
   localparam logic [7:0] CLK_IDLE  = 8'(serdes_pkg::CLK_IDLE_CYC);
   localparam logic [7:0] DATA_IDLE = 8'(serdes_pkg::DATA_IDLE_CYC);

   pin_event_if pclk_ev ();
   pin_event_if rclk_ev ();
   pin_event_if lane_ev [2] ();

   logic [2:0]  ctl_meta;
   logic [2:0]  ctl_sync;
   logic [13:0] pdata_meta;
   logic [13:0] pdata_sync;

   // link clocks and serial lanes pass through watchers
   pin_watch #(.IDLE_CYC(CLK_IDLE)) u_pclk (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pin     (par_clk_in),
      .ev      (pclk_ev)
   );
   pin_watch #(.IDLE_CYC(CLK_IDLE)) u_rclk (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pin     (ser_clk_in),
      .ev      (rclk_ev)
   );
   for (genvar g = 0; g < serdes_pkg::LANES; g++) begin : g_lane
      pin_watch #(.IDLE_CYC(DATA_IDLE)) u_lane (
         .clk     (clk),
         .sys_rst (sys_rst),
         .pin     (ser_in[g]),
         .ev      (lane_ev[g])
      );
   end

   // control pins and parallel data pass two flip-flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctl_meta   <= 3'h0;
         ctl_sync   <= 3'h0;
         pdata_meta <= 14'h0000;
         pdata_sync <= 14'h0000;
      end else begin
         ctl_meta   <= {edge_select, rx_enable, tx_enable};
         ctl_sync   <= ctl_meta;
         pdata_meta <= par_data_in;
         pdata_sync <= pdata_meta;
      end
   end

   wire tx_en   = ctl_sync[0];
   wire rx_en   = ctl_sync[1];
   wire rise_ed = ctl_sync[2];

   // ---------------- serializer half ----------------
   serdes_pkg::half_state_t tx_state;
   serdes_pkg::half_state_t next_tx_state;
   logic [17:0] tx_lock_cnt;
   logic [6:0]  tx_sh_a;
   logic [6:0]  tx_sh_b;
   logic [2:0]  tx_left;

   wire tx_lock_done = (tx_lock_cnt == TX_LOCK_CYCLES - 18'h00001) & pclk_ev.active;
   wire tx_strobe    = rise_ed ? pclk_ev.rise : pclk_ev.fall;
   wire tx_load      = (tx_state == serdes_pkg::HALF_RUN) & tx_strobe;
   wire tx_shift     = (tx_left != 3'h0);

   // transmit state: lock is lost with the enable or the input clock
   always_comb begin
      next_tx_state = tx_state;
      case (tx_state)
         serdes_pkg::HALF_OFF: begin
            if (tx_en) next_tx_state = serdes_pkg::HALF_LOCK;
         end
         serdes_pkg::HALF_LOCK: begin
            if (!tx_en) next_tx_state = serdes_pkg::HALF_OFF;
            else if (tx_lock_done) next_tx_state = serdes_pkg::HALF_RUN;
         end
         serdes_pkg::HALF_RUN: begin
            if (!tx_en) next_tx_state = serdes_pkg::HALF_OFF;
            else if (!pclk_ev.active) next_tx_state = serdes_pkg::HALF_LOCK;
         end
         default: next_tx_state = serdes_pkg::HALF_OFF;
      endcase
   end

   // lock timer counts only while the input clock toggles
   always_ff @(posedge clk) begin
      if (sys_rst || tx_state != serdes_pkg::HALF_LOCK || !pclk_ev.active) begin
         tx_lock_cnt <= 18'h00000;
      end else begin
         tx_lock_cnt <= tx_lock_cnt + 18'h00001;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) tx_state <= serdes_pkg::HALF_OFF;
      else tx_state <= next_tx_state;
   end

   // word load on the selected edge, then seven bits per lane, low bit first
   always_ff @(posedge clk) begin
      if (sys_rst || tx_state != serdes_pkg::HALF_RUN) begin
         tx_sh_a <= 7'h00;
         tx_sh_b <= 7'h00;
         tx_left <= 3'h0;
      end else if (tx_load) begin
         tx_sh_a <= pdata_sync[6:0];
         tx_sh_b <= pdata_sync[13:7];
         tx_left <= serdes_pkg::SLICE_BITS;
      end else if (tx_shift) begin
         tx_sh_a <= {1'b0, tx_sh_a[6:1]};
         tx_sh_b <= {1'b0, tx_sh_b[6:1]};
         tx_left <= tx_left - 3'h1;
      end
   end

   // serial outputs: released while disabled, quiet until locked
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ser_out        <= 2'h0;
         ser_out_oe     <= 1'b0;
         ser_clk_out    <= 1'b0;
         ser_clk_out_oe <= 1'b0;
         tx_locked      <= 1'b0;
      end else begin
         ser_out        <= tx_shift ? {tx_sh_b[0], tx_sh_a[0]} : 2'h0;
         ser_out_oe     <= (next_tx_state != serdes_pkg::HALF_OFF);
         ser_clk_out    <= (tx_state == serdes_pkg::HALF_RUN) & pclk_ev.level;
         ser_clk_out_oe <= (next_tx_state != serdes_pkg::HALF_OFF);
         tx_locked      <= (next_tx_state == serdes_pkg::HALF_RUN);
      end
   end

   // ---------------- deserializer half ----------------
   serdes_pkg::half_state_t rx_state;
   serdes_pkg::half_state_t next_rx_state;
   logic [17:0] rx_lock_cnt;
   logic [6:0]  rx_sh_a;
   logic [6:0]  rx_sh_b;
   logic [2:0]  rx_idx;
   logic        rx_busy;
   logic        rx_done;

   wire rx_run       = (rx_state == serdes_pkg::HALF_RUN);
   wire rx_lock_done = (rx_lock_cnt == RX_LOCK_CYCLES - 18'h00001) & rclk_ev.active;
   wire data_idle    = ~lane_ev[0].active & ~lane_ev[1].active;
   wire rx_start     = rx_run & rclk_ev.rise;

   // receive state: lock is lost with the enable or the link clock
   always_comb begin
      next_rx_state = rx_state;
      case (rx_state)
         serdes_pkg::HALF_OFF: begin
            if (rx_en) next_rx_state = serdes_pkg::HALF_LOCK;
         end
         serdes_pkg::HALF_LOCK: begin
            if (!rx_en) next_rx_state = serdes_pkg::HALF_OFF;
            else if (rx_lock_done) next_rx_state = serdes_pkg::HALF_RUN;
         end
         serdes_pkg::HALF_RUN: begin
            if (!rx_en) next_rx_state = serdes_pkg::HALF_OFF;
            else if (!rclk_ev.active) next_rx_state = serdes_pkg::HALF_LOCK;
         end
         default: next_rx_state = serdes_pkg::HALF_OFF;
      endcase
   end

   // lock timer counts only while the link clock toggles
   always_ff @(posedge clk) begin
      if (sys_rst || rx_state != serdes_pkg::HALF_LOCK || !rclk_ev.active) begin
         rx_lock_cnt <= 18'h00000;
      end else begin
         rx_lock_cnt <= rx_lock_cnt + 18'h00001;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) rx_state <= serdes_pkg::HALF_OFF;
      else rx_state <= next_rx_state;
   end

   // seven samples per lane after each link clock rise, low bit first
   always_ff @(posedge clk) begin
      if (sys_rst || !rx_run) begin
         rx_busy <= 1'b0;
         rx_idx  <= 3'h0;
         rx_done <= 1'b0;
      end else begin
         rx_done <= rx_busy & (rx_idx == serdes_pkg::SLICE_LAST);
         if (rx_start && !rx_busy) begin
            rx_busy <= 1'b1;
            rx_idx  <= 3'h0;
         end else if (rx_busy) begin
            rx_busy <= (rx_idx != serdes_pkg::SLICE_LAST);
            rx_idx  <= rx_idx + 3'h1;
         end
      end
   end

   // lane shifters
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_sh_a <= 7'h00;
         rx_sh_b <= 7'h00;
      end else if (rx_busy) begin
         rx_sh_a <= {lane_ev[0].level, rx_sh_a[6:1]};
         rx_sh_b <= {lane_ev[1].level, rx_sh_b[6:1]};
      end
   end

   // parallel outputs with failsafe states
   always_ff @(posedge clk) begin
      if (sys_rst || next_rx_state == serdes_pkg::HALF_OFF) begin
         par_data_out <= 14'h0000;
         par_clk_out  <= 1'b0;
      end else begin
         if (rx_run && rclk_ev.active && data_idle) begin
            par_data_out <= 14'h3fff;
         end else if (rx_done) begin
            par_data_out <= {rx_sh_b, rx_sh_a};
         end
         par_clk_out <= rx_run & rclk_ev.active & rclk_ev.level;
      end
   end

   // lock status
   always_ff @(posedge clk) begin
      if (sys_rst) rx_locked <= 1'b0;
      else rx_locked <= (next_rx_state == serdes_pkg::HALF_RUN);
   end
endmodule : serdes_enable_failsafe_ctrl

// [serdes_far_end.sv]
// far end of the link: forwards a 320 ns clock and, when asked, one word per clock period
module serdes_far_end (
   // frame control
   input  wire logic        run,
   input  wire logic        send,
   input  wire logic [13:0] word,
   // serial lines into the block
   output logic             ser_clk_in,
   output logic [1:0]       ser_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // clock toggles only within a frame and stands low between frames
   initial begin
      ser_clk_in = 1'b0;
      #13;
      forever #160 ser_clk_in = run ? ~ser_clk_in : 1'b0;
   end
   // seven bits per lane after each clock rise, low bit first, 40 ns apart;
   // bits change halfway between system clock rising edges, lanes hold still otherwise
   initial begin
      ser_in = 2'h1;
      forever begin
         @(posedge ser_clk_in);
         if (send) begin
            #27;
            for (int k = 0; k < 7; k++) begin
               ser_in = {word[k + 7], word[k]};
               #40;
            end
         end
      end
   end
endmodule : serdes_far_end

// [serdes_pkg.sv]
// constants, types and state encodings of the serdes enable and failsafe control
// Contract
// - no ordering needed between enables and arrival of clock or data
// - recover after clock and data stop and return, without toggling the enable
// - serializer enable low: serial outputs high impedance, transmit lock lost, serializer reset
// - deserializer enable low: receiver outputs low, receive lock lost, deserializer reset
// - enabled, clock valid, data idle: all parallel outputs high, clock still forwarded
// - enabled, clock idle: parallel data holds last value, output clock low
// - deserializer disabled: parallel data and output clock low whatever the inputs
package serdes_pkg;
   // system clock rate
   localparam int CLK_HZ        = 25_000_000;
   localparam int CYC_PER_US    = CLK_HZ / 1_000_000;
   // lock acquisition time, in ms, and its count of clock cycles
   localparam int LOCK_TIME_MS  = 10;
   localparam int LOCK_CYC      = LOCK_TIME_MS * (CLK_HZ / 1000);
   localparam int LOCK_W        = 18;
   // a link clock with no edge for this long counts as idle (least time, rounded up)
   localparam int CLK_IDLE_NS   = 1000;
   localparam int CLK_IDLE_CYC  = (CLK_IDLE_NS * CYC_PER_US + 999) / 1000;
   // a data lane with no transition for this long counts as idle
   localparam int DATA_IDLE_NS  = 2000;
   localparam int DATA_IDLE_CYC = (DATA_IDLE_NS * CYC_PER_US + 999) / 1000;
   localparam int IDLE_W        = 8;
   // word layout: two lanes of seven bits
   localparam int PAR_W         = 14;
   localparam int LANES         = 2;
   localparam int SLICE_W       = 7;
   localparam logic [2:0] SLICE_LAST = 3'h6;
   localparam logic [2:0] SLICE_BITS = 3'h7;
   // one-hot states of each half
   typedef enum logic [2:0] {
      HALF_OFF  = 3'h1,
      HALF_LOCK = 3'h2,
      HALF_RUN  = 3'h4
   } half_state_t;
endpackage : serdes_pkg

// [tb_serdes_enable_failsafe_ctrl.sv]
// self-checking bench for the serdes enable and failsafe control
module tb_serdes_enable_failsafe_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [17:0] LOCK_SIM = 18'h14;
   localparam logic [13:0] TX_WORD  = 14'h2a5c;
   localparam logic [13:0] RX_WORD  = 14'h1b39;
   logic        clk, sys_rst, tx_enable, rx_enable, par_clk_in, ser_clk_in;
   logic        ser_out_oe, ser_clk_out, ser_clk_out_oe, par_clk_out;
   logic        tx_locked, rx_locked, link_run, tx_run, link_send, edge_select;
   logic [1:0]  ser_out, ser_in;
   logic [13:0] par_data_out;
   int          errors = 0;
   int          samples_checked = 0;
   int          cycles = 0;

   serdes_enable_failsafe_ctrl #(.TX_LOCK_CYCLES(LOCK_SIM), .RX_LOCK_CYCLES(LOCK_SIM))
   u_serdes_enable_failsafe_ctrl (
      .clk, .sys_rst, .tx_enable, .rx_enable, .edge_select, .par_clk_in,
      .par_data_in(TX_WORD), .ser_out, .ser_out_oe, .ser_clk_out, .ser_clk_out_oe,
      .ser_in, .ser_clk_in, .par_data_out, .par_clk_out, .tx_locked, .rx_locked
   );
   serdes_far_end u_serdes_far_end (
      .run(link_run), .send(link_send), .word(RX_WORD), .ser_clk_in, .ser_in
   );

   // system clock and parallel transmit clock (only while tx_run)
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      par_clk_in = 1'b0;
      forever #160 par_clk_in = tx_run ? ~par_clk_in : 1'b0;
   end
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         results();
      end
   end

   task automatic check(input logic [13:0] seen, input logic [13:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : step
   task automatic wait_lock(input logic tx);
      for (int i = 0; i < 200; i++) begin
         if ((tx ? tx_locked : rx_locked) === 1'b1) break;
         step(1);
      end
      check(tx ? tx_locked : rx_locked, 14'h1);
   endtask : wait_lock

   task automatic t_enable_first();
      step(40);
      check(tx_locked, 14'h0);
      check(ser_out_oe, 14'h1);
      tx_run = 1'b1;
      link_run = 1'b1;
      step(10);
      check(rx_locked, 14'h0);
      wait_lock(1'b1);
      wait_lock(1'b0);
   endtask : t_enable_first
   task automatic t_failsafe();
      logic seen;
      seen = 1'b0;
      step(60);
      check(par_data_out, 14'h3fff);
      repeat (16) begin
         step(1);
         seen |= par_clk_out;
      end
      check(seen, 14'h1);
   endtask : t_failsafe
   // one word on the lanes: bit k of each lane comes one cycle after the forwarded
   // clock reaches the selected level, plus k cycles
   task automatic t_tx_word(input logic sel);
      logic [6:0] lane_a;
      logic [6:0] lane_b;
      int         n;
      edge_select = sel;
      step(10);
      n = 0;
      while (ser_clk_out === sel && n < 20) begin
         step(1);
         n++;
      end
      while (ser_clk_out !== sel && n < 40) begin
         step(1);
         n++;
      end
      for (int k = 0; k < 7; k++) begin
         step(1);
         lane_a[k] = ser_out[0];
         lane_b[k] = ser_out[1];
      end
      check({lane_b, lane_a}, TX_WORD);
   endtask : t_tx_word
   task automatic t_clock_stop();
      link_send = 1'b1;
      step(40);
      check(par_data_out, RX_WORD);
      link_run = 1'b0;
      tx_run = 1'b0;
      step(50);
      check(rx_locked, 14'h0);
      check(par_clk_out, 14'h0);
      check(par_data_out, RX_WORD);
      check(tx_locked, 14'h0);
      link_send = 1'b0;
      link_run = 1'b1;
      tx_run = 1'b1;
      wait_lock(1'b1);
      wait_lock(1'b0);
      step(60);
      check(par_data_out, 14'h3fff);
   endtask : t_clock_stop
   task automatic t_rx_disable();
      rx_enable = 1'b0;
      step(8);
      check(par_data_out, 14'h0);
      check(par_clk_out, 14'h0);
      check(rx_locked, 14'h0);
      rx_enable = 1'b1;
      step(10);
      check(rx_locked, 14'h0);
      wait_lock(1'b0);
   endtask : t_rx_disable
   task automatic t_tx_disable();
      tx_enable = 1'b0;
      step(8);
      check(ser_out_oe, 14'h0);
      check(ser_clk_out_oe, 14'h0);
      check(tx_locked, 14'h0);
      tx_enable = 1'b1;
      step(6);
      check(tx_locked, 14'h0);
      wait_lock(1'b1);
   endtask : t_tx_disable

   task automatic results();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   // enables already high through reset, clocks absent
   initial begin
      tx_enable = 1'b1;
      rx_enable = 1'b1;
      sys_rst = 1'b1;
      tx_run = 1'b0;
      link_run = 1'b0;
      link_send = 1'b0;
      edge_select = 1'b1;
      step(4);
      sys_rst = 1'b0;
      t_enable_first();
      t_failsafe();
      t_tx_word(1'b1);
      t_tx_word(1'b0);
      t_clock_stop();
      t_rx_disable();
      t_tx_disable();
      results();
   end
endmodule : tb_serdes_enable_failsafe_ctrl
